// ===== design/sepm_port.sv
/*
 * Serial memory command port: decodes instructions, reads, and runs self-timed programming.
 * Assumes chip select, serial clock and serial input arrive asynchronously on pins.
 */
`timescale 1ns/100ps
module sepm_port #(
  parameter int unsigned PROG_CYC    = sepm_pkg::PROG_CYCLES,
  parameter int unsigned POWERUP_CYC = sepm_pkg::POWERUP_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic chip_select,
  input  wire logic serial_clock,
  input  wire logic serial_in,
  input  wire logic word_width_select,
  output logic      serial_out,
  output logic      serial_out_en,
  output logic      busy,
  output logic      ready_for_ops
);
  import sepm_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] cs_s_q;
  logic [2:0] sk_s_q;
  logic [2:0] di_s_q;
  logic [2:0] org_s_q;
  logic       cs_q;
  logic       sk_q;
  logic       di_q;
  logic       org_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cs_s_q  <= 3'h0;
      sk_s_q  <= 3'h0;
      di_s_q  <= 3'h0;
      org_s_q <= 3'h7;
      cs_q    <= 1'b0;
      sk_q    <= 1'b0;
      di_q    <= 1'b0;
      org_q   <= 1'b1;
    end else begin
      cs_s_q  <= {cs_s_q[1:0], chip_select};
      sk_s_q  <= {sk_s_q[1:0], serial_clock};
      di_s_q  <= {di_s_q[1:0], serial_in};
      org_s_q <= {org_s_q[1:0], word_width_select};
      if (cs_s_q[1] == cs_s_q[2]) cs_q <= cs_s_q[2];
      if (sk_s_q[1] == sk_s_q[2]) sk_q <= sk_s_q[2];
      if (di_s_q[1] == di_s_q[2]) di_q <= di_s_q[2];
      if (org_s_q[1] == org_s_q[2]) org_q <= org_s_q[2];
    end
  end

  wire sk_rise = (sk_s_q[1] == sk_s_q[2]) && sk_s_q[2] && !sk_q;
  wire cs_fall = (cs_s_q[1] == cs_s_q[2]) && !cs_s_q[2] && cs_q;
  wire cs_on   = cs_q && cs_s_q[2];
  wire din     = (di_s_q[1] == di_s_q[2]) ? di_s_q[2] : di_q;

  // ****************************************
  // memory and helpers
  // ****************************************
  logic [15:0] mem [0:127];
  logic [7:0]  mem8_unused;

  function automatic logic [15:0] read_word(input logic [15:0] w, input logic x16, input logic lo);
    read_word = x16 ? w : {(lo ? w[7:0] : w[15:8]), 8'h00};
  endfunction

  // ****************************************
  // two-entry store buffer between decoder and programming engine
  // ****************************************
  sepm_prog_s buf_q [0:1];
  logic [1:0] buf_cnt_q;
  logic       buf_wr_q;
  logic       buf_rd_q;
  wire        buf_in_ready  = (buf_cnt_q != 2'h2);
  wire        buf_out_valid = (buf_cnt_q != 2'h0);

  // ****************************************
  // state
  // ****************************************
  sepm_state_e st_q;
  logic [4:0]  cnt_q;
  logic [4:0]  len_q;
  logic [11:0] cmd_q;
  logic [15:0] data_q;
  logic [15:0] shift_q;
  logic [8:0]  raddr_q;
  logic        enable_q;
  logic        x16_q;
  logic        dummy_q;
  logic [31:0] prog_q;
  logic [31:0] pwr_q;
  sepm_prog_s  pend_q;
  logic        pend_v_q;

  wire [4:0]  cmd_len   = x16_q ? 5'(LEN_X16) : 5'(LEN_X8);
  wire [1:0]  opcode    = x16_q ? cmd_q[9:8] : cmd_q[10:9];
  wire [8:0]  addr_f    = x16_q ? {2'h0, cmd_q[6:0]} : {1'b0, cmd_q[7:0]};   // top bit ignored
  wire [1:0]  sub       = x16_q ? cmd_q[7:6] : cmd_q[8:7];
  wire        need_data = (opcode == OP_WRITE) || (opcode == OP_SPECIAL && sub == SUB_FILL);
  wire [4:0]  data_len  = x16_q ? 5'd16 : 5'd8;
  wire [8:0]  addr_max  = x16_q ? 9'h07f : 9'h0ff;
  wire [8:0]  addr_next = (raddr_q == addr_max) ? 9'h000 : raddr_q + 9'h001;
  wire [15:0] rword     = read_word(mem[x16_q ? raddr_q[6:0] : raddr_q[7:1]], x16_q, raddr_q[0]);
  // next word fetched ahead so a sequential read needs no gap bit
  wire [15:0] nword     = read_word(mem[x16_q ? addr_next[6:0] : addr_next[7:1]], x16_q, addr_next[0]);
  wire        prog_busy = buf_out_valid || (prog_q != 32'h0);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q          <= ST_IDLE;
      cnt_q         <= 5'h0;
      len_q         <= 5'h0;
      cmd_q         <= 12'h0;
      data_q        <= 16'h0;
      shift_q       <= 16'h0;
      raddr_q       <= 9'h0;
      enable_q      <= ENABLE_RESET;
      x16_q         <= 1'b1;
      dummy_q       <= 1'b0;
      pend_q        <= '0;
      pend_v_q      <= 1'b0;
      buf_wr_q      <= 1'b0;
      serial_out    <= 1'b1;
      serial_out_en <= 1'b0;
    end else begin
      buf_wr_q <= 1'b0;
      if (!cs_on) begin
        serial_out_en <= 1'b0;
        if (cs_fall && pend_v_q && buf_in_ready) buf_wr_q <= 1'b1;
        pend_v_q <= 1'b0;
        if (st_q != ST_IDLE) st_q <= ST_IDLE;
      end else case (st_q)
        ST_IDLE: begin
          x16_q <= org_q;
          if (prog_busy) begin
            serial_out_en <= 1'b1;
            serial_out    <= 1'b0;
            st_q <= ST_WAIT;
          end else if (sk_rise && din) begin
            cnt_q <= 5'h1;
            cmd_q <= 12'h1;
            st_q  <= ST_CMD;
          end
        end
        ST_WAIT: begin
          serial_out <= !prog_busy;
          if (sk_rise && din) serial_out_en <= 1'b0;
        end
        ST_CMD: if (sk_rise) begin
          cmd_q <= {cmd_q[10:0], din};
          cnt_q <= cnt_q + 5'h1;
          if (cnt_q + 5'h1 == cmd_len) st_q <= ST_ARMED;
        end
        ST_ARMED: begin
          cnt_q <= 5'h0;
          st_q  <= ST_IDLE;
          if (opcode == OP_READ) begin
            raddr_q       <= addr_f;
            serial_out_en <= 1'b1;
            serial_out    <= 1'b0;
            dummy_q       <= 1'b1;
            st_q          <= ST_READ;
          end else if (need_data) st_q <= ST_DATA;
          else if (opcode == OP_SPECIAL && sub == SUB_ENABLE) enable_q <= 1'b1;
          else if (opcode == OP_SPECIAL && sub == SUB_DISABLE) enable_q <= 1'b0;
          else if (enable_q) begin
            pend_q   <= '{fill: 1'b0, all: (opcode == OP_SPECIAL), erase: 1'b1,
                          addr: addr_f[7:0], data: 16'hffff};
            pend_v_q <= 1'b1;
            st_q     <= ST_WAIT;
            serial_out_en <= 1'b0;
          end
        end
        ST_DATA: if (sk_rise) begin
          data_q <= {data_q[14:0], din};
          cnt_q  <= cnt_q + 5'h1;
          if (cnt_q + 5'h1 == data_len) begin
            if (enable_q) begin
              pend_q <= '{fill: (opcode == OP_SPECIAL), all: (opcode == OP_SPECIAL), erase: 1'b0,
                          addr: addr_f[7:0], data: {data_q[14:0], din}};
              pend_v_q <= 1'b1;
            end
            st_q <= ST_WAIT;
          end
        end
        ST_READ: if (sk_rise) begin
          if (dummy_q) begin
            dummy_q    <= 1'b0;
            shift_q    <= rword << 1;
            serial_out <= rword[15];
            cnt_q      <= 5'h1;
          end else if (cnt_q == data_len) begin
            raddr_q    <= addr_next;
            cnt_q      <= 5'h1;
            serial_out <= nword[15];
            shift_q    <= nword << 1;
          end else begin
            serial_out <= shift_q[15];
            shift_q    <= shift_q << 1;
            cnt_q      <= cnt_q + 5'h1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // self-timed programming engine, no serial clock needed
  // ****************************************
  sepm_prog_s cur;
  assign cur = buf_q[buf_rd_q];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      buf_cnt_q     <= 2'h0;
      buf_rd_q      <= 1'b0;
      prog_q        <= 32'h0;
      pwr_q         <= 32'(POWERUP_CYC);
      busy          <= 1'b0;
      ready_for_ops <= 1'b0;
    end else begin
      if (pwr_q != 32'h0) pwr_q <= pwr_q - 32'h1;
      ready_for_ops <= (pwr_q == 32'h0);
      busy <= prog_busy;
      if (buf_wr_q) buf_q[buf_rd_q ^ buf_cnt_q[0]] <= pend_q;
      if (prog_q == 32'h0 && buf_out_valid) prog_q <= 32'(PROG_CYC);
      else if (prog_q == 32'h1) begin
        for (int i = 0; i < 128; i++)
          if (cur.all || i == (x16_q ? int'(cur.addr[6:0]) : int'(cur.addr[7:1])))
            mem[i] <= (x16_q || cur.erase) ? cur.data
                      : (cur.all ? {cur.data[7:0], cur.data[7:0]}
                      : (cur.addr[0] ? {mem[i][15:8], cur.data[7:0]} : {cur.data[7:0], mem[i][7:0]}));
        buf_rd_q  <= !buf_rd_q;
        prog_q    <= 32'h0;
        buf_cnt_q <= buf_cnt_q - 2'h1 + {1'b0, buf_wr_q};
      end else begin
        if (prog_q != 32'h0) prog_q <= prog_q - 32'h1;
        buf_cnt_q <= buf_cnt_q + {1'b0, buf_wr_q};
      end
    end
  end
  assign mem8_unused = 8'h00;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  out_float_a: assert property (
    !cs_on |=> !serial_out_en)
    else $error("output driven while deselected");
  busy_level_a: assert property (
    st_q == ST_WAIT && serial_out_en && prog_busy |=> serial_out == 1'b0 || !serial_out_en || !cs_on)
    else $error("busy not low");
  dummy_release_a: assert property (
    st_q == ST_WAIT && cs_on && sk_rise && din |=> !serial_out_en)
    else $error("dummy one ignored");
  read_dummy_a: assert property (
    st_q == ST_ARMED && cs_on && opcode == OP_READ |=> serial_out_en && !serial_out)
    else $error("no dummy zero");
  first_bit_a: assert property (
    st_q == ST_READ && cs_on && sk_rise && dummy_q |=> !dummy_q && serial_out == $past(rword[15]))
    else $error("first data bit wrong");
  wrap_addr_a: assert property (
    st_q == ST_READ && cs_on && sk_rise && !dummy_q && cnt_q == data_len && raddr_q == addr_max |=> raddr_q == 9'h0)
    else $error("read wrap wrong");
  seq_gap_a: assert property (
    st_q == ST_READ && cs_on && sk_rise && !dummy_q && cnt_q == data_len |=> !dummy_q && cnt_q == 5'h1)
    else $error("gap bit between words");
  cmd_len_a: assert property (
    st_q == ST_CMD && cs_on && sk_rise && cnt_q + 5'h1 == cmd_len |=> st_q == ST_ARMED)
    else $error("instruction length wrong");
  protect_a: assert property (
    !enable_q && st_q == ST_DATA |=> !pend_v_q)
    else $error("write while protected");
  enable_hold_a: assert property (
    enable_q && !(st_q == ST_ARMED && opcode == OP_SPECIAL && sub == SUB_DISABLE) |=> enable_q)
    else $error("enable dropped");
  job_start_a: assert property (
    cs_fall && pend_v_q && buf_in_ready |=> buf_wr_q)
    else $error("job not started on deselect");
  job_done_a: assert property (
    prog_q == 32'h1 && buf_cnt_q == 2'h1 && !buf_wr_q |=> !prog_busy)
    else $error("job did not finish");
  abort_a: assert property (
    st_q == ST_CMD && !cs_on |=> st_q == ST_IDLE && !pend_v_q)
    else $error("partial command kept");
  seq_read_c: cover property (st_q == ST_READ && sk_rise && cnt_q == data_len);
  prog_run_c: cover property (prog_q == 32'h1);
  poll_c: cover property (st_q == ST_WAIT && serial_out_en && serial_out);
  fill_run_c: cover property (prog_q == 32'h1 && cur.fill);
  byte_read_c: cover property (st_q == ST_READ && !x16_q && sk_rise);
endmodule

// ===== design/sepm_pkg.sv
/*
 * Constants, types and the operation summary for the serial memory command port.
 * Assumes a single 20 MHz system clock; the link pins pass through three-stage synchronisers in the port.
 */
// Summary of operation
// - instructions are 11 bits in word mode, 12 bits in byte mode
// - serial_in bits are captured on each rising serial clock edge
// - output stays undriven except during read data or busy status
// - after programming starts, reselect shows low while busy, high when ready
// - a dummy one shifted during status returns output to undriven
// - start bit one, two-bit opcode, address, then data for write types
// - opcode 10 reads, 11 erases, 01 writes one location
// - opcode 00 picks enable, disable, erase array or fill array by address bits
// - read sends one dummy zero then the word, most significant bit first
// - read output bits change on the rising serial clock edge
// - continued clocking reads next address, wrapping to zero
// - dummy zero precedes only the first word of a sequential read
// - programming disabled after power-up until enable command
// - enable holds until disable command or power loss
// - reads work whether programming is enabled or not
// - falling chip select after write starts self-timed clear and store
// - self-timed cycle finishes without serial clock pulses
// - single write clears location before storing
// - single erase sets the location to all ones
// - erase array sets every location to all ones
// - fill array stores the data word into every location
// - width select high gives 16-bit words, low gives 8-bit
package sepm_pkg;
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned PROG_TIME_US    = 5000;
  localparam int unsigned PROG_CYCLES     = PROG_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned POWERUP_TIME_US = 1000;
  localparam int unsigned POWERUP_CYCLES  = POWERUP_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LEN_X16         = 11;
  localparam int unsigned LEN_X8          = 12;
  localparam int unsigned ADDR_POS_X16    = 3;
  localparam logic [1:0]  OP_SPECIAL      = 2'h0;
  localparam logic [1:0]  OP_WRITE        = 2'h1;
  localparam logic [1:0]  OP_READ         = 2'h2;
  localparam logic [1:0]  OP_ERASE        = 2'h3;
  localparam logic [1:0]  SUB_DISABLE     = 2'h0;
  localparam logic [1:0]  SUB_FILL        = 2'h1;
  localparam logic [1:0]  SUB_ERASE_ALL   = 2'h2;
  localparam logic [1:0]  SUB_ENABLE      = 2'h3;
  localparam logic        ENABLE_RESET    = 1'b0;

  typedef enum {
    ST_IDLE, ST_CMD, ST_DATA, ST_ARMED, ST_READ, ST_WAIT
  } sepm_state_e;

  typedef struct packed {
    logic sel;
    logic sclk;
    logic din;
  } sepm_pins_s;

  typedef struct packed {
    logic       fill;
    logic       all;
    logic       erase;
    logic [7:0] addr;
    logic [15:0] data;
  } sepm_prog_s;
endpackage

// ===== testbench/sepm_host.sv
/*
 * Host-side model that drives the serial pins of the memory port.
 * Assumes the bench clock; pins change only just after its rising edge.
 */
`timescale 1ns/100ps
module sepm_host (
  input  wire logic clk,
  input  wire logic serial_out,
  output logic      chip_select,
  output logic      serial_clock,
  output logic      serial_in
);
  initial begin
    chip_select = 1'b0;
    serial_clock = 1'b0;
    serial_in = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // six clocks a phase: the port synchronises the pins first
  task automatic tick(input logic b, output logic o);
    serial_in <= b;
    serial_clock <= 1'b0;
    wt(6);
    serial_clock <= 1'b1;
    wt(6);
    o = serial_out;
  endtask
  task automatic send(input int n, input logic [27:0] v, output logic o);
    for (int i = n - 1; i >= 0; i--) begin
      tick(v[i], o);
    end
  endtask
  task automatic sel();
    chip_select <= 1'b1;
    wt(6);
  endtask
  // clock stands low between frames; data line shows no stale copy
  task automatic desel();
    serial_clock <= 1'b0;
    wt(6);
    chip_select <= 1'b0;
    serial_in <= ~serial_in;
    // deselect needs four clocks to reach the output enable
    wt(5);
  endtask
endmodule

// ===== testbench/testbench.sv
/*
 * Self-checking bench for the serial memory command port.
 * Assumes sepm_pkg and the host model are compiled first.
 */
`timescale 1ns/100ps
module testbench;
  import sepm_pkg::*;
  logic clk, reset, wws, cs, sck, sdi;
  logic sdo, sdo_en, busy, rdy;
  int   mismatches, total_checks, cycles;
  sepm_port #(.PROG_CYC(40), .POWERUP_CYC(10)) dut (
    .clk(clk), .reset(reset), .chip_select(cs), .serial_clock(sck),
    .serial_in(sdi), .word_width_select(wws), .serial_out(sdo),
    .serial_out_en(sdo_en), .busy(busy), .ready_for_ops(rdy));
  sepm_host h (.clk(clk), .serial_out(sdo), .chip_select(cs),
    .serial_clock(sck), .serial_in(sdi));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ********************************
  // checking and shared transfers
  // ********************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmd(input int n, input logic [27:0] v);
    logic o;
    h.sel();
    h.send(n, v, o);
    h.desel();
  endtask
  task automatic rd(input int n, input logic [27:0] v, input int nb, input logic [63:0] e);
    logic        o;
    logic [63:0] g;
    g = '0;
    h.sel();
    h.send(n, v, o);
    chk("dummy bit", 64'h2, {sdo_en, o});
    for (int i = 0; i < nb; i++) begin
      h.tick(1'b0, o);
      g = {g[62:0], o};
    end
    chk("read data", e, g);
    h.desel();
    chk("released", 64'h0, sdo_en);
  endtask
  // no serial clock while polling: the job must time itself
  task automatic pwait();
    logic o;
    int   n;
    h.wt(4);
    chk("busy", 64'h1, busy);
    h.sel();
    chk("status low", 64'h2, {sdo_en, sdo});
    n = 0;
    while (sdo !== 1'b1 && n < 200) begin
      h.wt(1);
      n++;
    end
    chk("status high", 64'h6, {sdo_en, sdo, busy});
    h.tick(1'b1, o);
    chk("status release", 64'h0, sdo_en);
    h.desel();
  endtask
  // ********************************
  // scenarios
  // ********************************
  task automatic t_protect();
    cmd(27, {3'b101, 8'h05, 16'h1234});
    chk("busy disabled", 64'h0, busy);
  endtask
  task automatic t_fill();
    cmd(11, {3'b100, 8'hc0});
    cmd(27, {3'b100, 8'h40, 16'ha5a5});
    pwait();
  endtask
  task automatic t_single();
    cmd(27, {3'b101, 8'h03, 16'h1234});
    pwait();
    cmd(11, {3'b111, 8'h04});
    pwait();
    cmd(27, {3'b101, 8'h80, 16'h0ff0});
    pwait();
    rd(11, {3'b110, 8'h03}, 48, {16'h1234, 16'hffff, 16'ha5a5});
    rd(11, {3'b110, 8'h7f}, 32, {16'ha5a5, 16'h0ff0});
  endtask
  task automatic t_bytes();
    wws <= 1'b0;
    rd(12, {3'b110, 9'h006}, 16, {16'h1234});
    wws <= 1'b1;
  endtask
  task automatic t_erase_all();
    cmd(11, {3'b100, 8'h80});
    pwait();
    rd(11, {3'b110, 8'h03}, 16, {16'hffff});
  endtask
  task automatic t_disable();
    cmd(11, {3'b100, 8'h00});
    cmd(6, {22'h0, 6'b100110});
    cmd(27, {3'b101, 8'h03, 16'h0000});
    chk("busy after abort", 64'h0, busy);
    rd(11, {3'b110, 8'h03}, 16, {16'hffff});
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    reset = 1'b1;
    wws = 1'b1;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("reset outputs", 64'h0, {sdo_en, busy, rdy});
    repeat (14) @(posedge clk);
    chk("ready", 64'h1, rdy);
    t_protect();
    t_fill();
    t_single();
    t_bytes();
    t_erase_all();
    t_disable();
    complete_run();
  end
endmodule
